// ---- core/cpirq_pkg.sv ----
package cpirq_pkg;
   // Slot numbering in mask and latch
   localparam int CPIRQ_SLOTS = 16;
   localparam logic [3:0] CPIRQ_SLOT_RESET = 4'h0;
   localparam logic [3:0] CPIRQ_SLOT_PWRDN = 4'h1;
   localparam logic [3:0] CPIRQ_SLOT_STACK = 4'h2;
   localparam logic [3:0] CPIRQ_SLOT_EMUK = 4'h3;
   localparam logic [3:0] CPIRQ_SLOT_USER0 = 4'h4;
   localparam int CPIRQ_USER_SLOTS = 12;
   // Vector placement
   localparam logic [23:0] CPIRQ_VEC_BASE = 24'h00_0000;
   localparam logic [23:0] CPIRQ_VEC_STEP = 24'h00_0020;
   // Peripheral mapping
   localparam int CPIRQ_PERIPH = 32;
   localparam int CPIRQ_MAP_REGS = 8;
   localparam int CPIRQ_CODE_W = 4;
   localparam logic [3:0] CPIRQ_CODE_MAX = 4'hB;
   localparam logic [15:0] CPIRQ_MAP_RESET = 16'hFFFF;
   // Register reset values
   localparam logic [15:0] CPIRQ_MASK_RESET = 16'h0000;
   localparam logic [15:0] CPIRQ_LATCH_RESET = 16'h0000;
   // Stack depths and stack-level thresholds
   localparam int CPIRQ_PC_DEPTH = 33;
   localparam int CPIRQ_LOOP_DEPTH = 8;
   localparam int CPIRQ_STAT_DEPTH = 16;
   localparam logic [5:0] CPIRQ_PC_LOW = 6'h03;
   localparam logic [5:0] CPIRQ_PC_HIGH = 6'h1C;
   // Register select codes for the register port
   localparam logic [3:0] CPIRQ_SEL_MASK = 4'h0;
   localparam logic [3:0] CPIRQ_SEL_LATCH = 4'h1;
   localparam logic [3:0] CPIRQ_SEL_CTRL = 4'h2;
   localparam logic [3:0] CPIRQ_SEL_MAP0 = 4'h8;
   // Control bit positions
   localparam int CPIRQ_CTRL_NEST = 0;
   localparam int CPIRQ_CTRL_GIE = 1;

   // Register access from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] sel;
      logic [15:0] wdata;
   } cpirq_reg_req_t;

   // Sequencer handshake and stack events
   typedef struct packed {
      logic ack;
      logic done;
      logic ena_int;
      logic dis_int;
      logic pc_push;
      logic pc_pop;
      logic loop_push;
      logic loop_pop;
   } cpirq_seq_t;
endpackage

// ---- core/cpirq_ctrl.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// RL1 - Seventeen sources, emulator on top, fixed priority
// RL2 - Slots 0..15, vectors 0x20 words apart
// RL3 - First user slot highest, twelfth lowest
// RL4 - Pending ANDed with mask, highest unmasked wins
// RL5 - Reset, power-down, emulation ignore mask; disable blocks power-down
// RL6 - Control register holds nesting and global enable
// RL7 - Latch writes force or clear pending slots
// RL8 - PC 33, loop 8, status 16 stacks
// RL9 - Stack interrupt below three or above 28
// RL10 - Enable/disable instructions override mask; off after reset
// RL11 - Thirty-two peripheral request lines routed coreward
// RL12 - Eight 16-bit map registers, four codes each
// RL13 - Code n below 0xC selects user slot n
// RL14 - Codes 0xC to 0xF disconnect source
// RL15 - Shared slot ORs its peripheral requests
// RL16 - No peripheral priority assigned after reset
// RL17 - Source k uses field k mod 4 of register k/4
// RL18 - Map fields reset to disabling code
module cpirq_ctrl
   import cpirq_pkg::*;
#(
   parameter int PERIPH_N = CPIRQ_PERIPH
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire cpirq_reg_req_t reg_req,
   input wire cpirq_seq_t seq,
   input wire logic [PERIPH_N-1:0] periph_irq,
   input wire logic emu_irq,
   input wire logic [CPIRQ_SLOTS-1:0] core_irq_src,
   output logic [15:0] reg_rdata,
   output logic irq_req,
   output logic emu_req,
   output logic [3:0] irq_slot,
   output logic [23:0] irq_vector,
   output logic [CPIRQ_SLOTS-1:0] irq_active,
   output logic [5:0] pc_stack_level,
   output logic [3:0] loop_stack_level,
   output logic [4:0] stat_stack_level
);
   logic [15:0] core_irq_mask_reg;
   logic [15:0] core_irq_latch_reg;
   logic [1:0] irq_nesting_control_reg;
   logic [15:0] map_reg [CPIRQ_MAP_REGS];
   logic [CPIRQ_PERIPH-1:0] periph_sync1_reg;
   logic [CPIRQ_PERIPH-1:0] periph_sync2_reg;
   logic [1:0] emu_sync_reg;
   logic [CPIRQ_USER_SLOTS-1:0] user_req;
   logic [CPIRQ_SLOTS-1:0] raise;
   logic [CPIRQ_SLOTS-1:0] eligible;
   logic [3:0] win_slot;
   logic win_valid;
   logic [3:0] act_top;
   logic act_any;
   logic stack_lvl_prev_reg;
   logic stack_lvl;
   logic take;
   logic [CPIRQ_PERIPH-1:0] periph_wide;

   // Peripheral and emulator lines come from other logic; sync anyway
   assign periph_wide = CPIRQ_PERIPH'(periph_irq);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         periph_sync1_reg <= '0;
         periph_sync2_reg <= '0;
         emu_sync_reg <= 2'b00;
      end else begin
         periph_sync1_reg <= periph_wide; // [RL11]
         periph_sync2_reg <= periph_sync1_reg;
         emu_sync_reg <= {emu_sync_reg[0], emu_irq};
      end
   end

   // Map fields decode into user slot requests
   always_comb begin
      user_req = '0;
      for (int k = 0; k < CPIRQ_PERIPH; k++) begin
         logic [3:0] code;
         code = map_reg[k / 4][4 * (k % 4) +: 4]; // [RL17] [RL12]
         if (periph_sync2_reg[k] && code <= CPIRQ_CODE_MAX) begin // [RL14]
            user_req[code] = 1'b1; // [RL13] [RL15]
         end
      end
   end

   // Stack-level condition, edge raises the latch bit
   assign stack_lvl = (pc_stack_level < CPIRQ_PC_LOW) || (pc_stack_level > CPIRQ_PC_HIGH); // [RL9]

   always_comb begin
      raise = core_irq_src;
      raise[CPIRQ_USER_SLOTS + 3:4] = raise[CPIRQ_USER_SLOTS + 3:4] | user_req;
      raise[CPIRQ_SLOT_STACK] = raise[CPIRQ_SLOT_STACK] | (stack_lvl & ~stack_lvl_prev_reg);
   end

   // Gate by mask; reset, power-down, emulation kernel bypass it
   always_comb begin
      eligible = core_irq_latch_reg & core_irq_mask_reg; // [RL4]
      eligible[CPIRQ_SLOT_RESET] = core_irq_latch_reg[CPIRQ_SLOT_RESET]; // [RL5]
      eligible[CPIRQ_SLOT_PWRDN] = core_irq_latch_reg[CPIRQ_SLOT_PWRDN];
      eligible[CPIRQ_SLOT_EMUK] = core_irq_latch_reg[CPIRQ_SLOT_EMUK];
      // Global disable blocks all but reset; power-down included
      if (!irq_nesting_control_reg[CPIRQ_CTRL_GIE]) begin
         eligible = eligible & 16'h0001; // [RL10] [RL5]
      end
   end

   // Lowest slot number wins: fixed priority
   always_comb begin
      win_slot = 4'h0;
      win_valid = 1'b0;
      for (int i = CPIRQ_SLOTS - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            win_slot = 4'(i); // [RL1] [RL3]
            win_valid = 1'b1;
         end
      end
   end

   // Highest priority handler currently running
   always_comb begin
      act_top = 4'h0;
      act_any = 1'b0;
      for (int i = CPIRQ_SLOTS - 1; i >= 0; i--) begin
         if (irq_active[i]) begin
            act_top = 4'(i);
            act_any = 1'b1;
         end
      end
   end

   // Accept the winner only if nesting allows preemption
   assign take = seq.ack && irq_req;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_req <= 1'b0;
         irq_slot <= 4'h0;
         irq_vector <= CPIRQ_VEC_BASE;
      end else if (take) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= win_valid && (!act_any ||
            (irq_nesting_control_reg[CPIRQ_CTRL_NEST] && win_slot < act_top)); // [RL6]
         irq_slot <= win_slot;
         irq_vector <= CPIRQ_VEC_BASE + (CPIRQ_VEC_STEP * {20'h0_0000, win_slot}); // [RL2]
      end
   end

   // Emulator request sits above everything and is never masked
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         emu_req <= 1'b0;
      end else begin
         emu_req <= emu_sync_reg[1]; // [RL1]
      end
   end

   // Active handlers: set on acceptance, cleared on the return
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_active <= '0;
      end else begin
         logic [CPIRQ_SLOTS-1:0] nxt;
         nxt = irq_active;
         if (seq.done && act_any) begin
            nxt[act_top] = 1'b0;
         end
         if (take) begin
            nxt[irq_slot] = 1'b1;
         end
         irq_active <= nxt;
      end
   end

   // Latch: hardware set beats software clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         core_irq_latch_reg <= CPIRQ_LATCH_RESET;
      end else begin
         logic [15:0] nxt;
         nxt = core_irq_latch_reg;
         if (reg_req.wr && reg_req.sel == CPIRQ_SEL_LATCH) begin
            nxt = reg_req.wdata; // [RL7]
         end
         if (take) begin
            nxt[irq_slot] = 1'b0;
         end
         core_irq_latch_reg <= nxt | raise;
      end
   end

   // Mask and control registers; enable/disable from the sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         core_irq_mask_reg <= CPIRQ_MASK_RESET;
         irq_nesting_control_reg <= 2'b00; // [RL10]
      end else begin
         if (reg_req.wr && reg_req.sel == CPIRQ_SEL_MASK) begin
            core_irq_mask_reg <= reg_req.wdata;
         end
         if (seq.ena_int) begin
            irq_nesting_control_reg[CPIRQ_CTRL_GIE] <= 1'b1; // [RL10]
         end else if (seq.dis_int) begin
            irq_nesting_control_reg[CPIRQ_CTRL_GIE] <= 1'b0;
         end else if (reg_req.wr && reg_req.sel == CPIRQ_SEL_CTRL) begin
            irq_nesting_control_reg <= reg_req.wdata[1:0]; // [RL6]
         end
      end
   end

   // Map registers start disconnected
   always_ff @(posedge sys_clk) begin
      for (int r = 0; r < CPIRQ_MAP_REGS; r++) begin
         if (sys_rst) begin
            map_reg[r] <= CPIRQ_MAP_RESET; // [RL16] [RL18]
         end else if (reg_req.wr && reg_req.sel == CPIRQ_SEL_MAP0 + 4'(r)) begin
            map_reg[r] <= reg_req.wdata;
         end
      end
   end

   // Stack levels track pushes and pops, saturating at depth
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pc_stack_level <= 6'h00;
         loop_stack_level <= 4'h0;
         stat_stack_level <= 5'h00;
         stack_lvl_prev_reg <= 1'b0;
      end else begin
         stack_lvl_prev_reg <= stack_lvl;
         if (seq.pc_push && !seq.pc_pop && pc_stack_level < 6'(CPIRQ_PC_DEPTH)) begin
            pc_stack_level <= pc_stack_level + 6'h01; // [RL8]
         end else if (seq.pc_pop && !seq.pc_push && pc_stack_level != 6'h00) begin
            pc_stack_level <= pc_stack_level - 6'h01;
         end
         if (seq.loop_push && !seq.loop_pop && loop_stack_level < 4'(CPIRQ_LOOP_DEPTH)) begin
            loop_stack_level <= loop_stack_level + 4'h1; // [RL8]
         end else if (seq.loop_pop && !seq.loop_push && loop_stack_level != 4'h0) begin
            loop_stack_level <= loop_stack_level - 4'h1;
         end
         // Status stack follows interrupt entry and return; entry plus return in one cycle nets out
         if (take && !seq.done && stat_stack_level < 5'(CPIRQ_STAT_DEPTH)) begin
            stat_stack_level <= stat_stack_level + 5'h01; // [RL8]
         end else if (seq.done && !take && stat_stack_level != 5'h00) begin
            stat_stack_level <= stat_stack_level - 5'h01;
         end
      end
   end

   // Read data, registered; unknown selects read zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_req.rd) begin
         if (reg_req.sel == CPIRQ_SEL_MASK) begin
            reg_rdata <= core_irq_mask_reg;
         end else if (reg_req.sel == CPIRQ_SEL_LATCH) begin
            reg_rdata <= core_irq_latch_reg;
         end else if (reg_req.sel == CPIRQ_SEL_CTRL) begin
            reg_rdata <= {14'h0000, irq_nesting_control_reg};
         end else if (reg_req.sel >= CPIRQ_SEL_MAP0) begin
            reg_rdata <= map_reg[reg_req.sel[2:0]];
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end
endmodule

// ---- verif/cpirq_seq_model.sv ----
`timescale 1ns/1ns
// Sequencer stand-in: takes each request, runs its handler, returns
module cpirq_seq_model (
   input wire logic sys_clk,
   input wire logic irq_req,
   input wire logic [7:0] run_len,
   output logic ack,
   output logic done
);
   int cnt = 0;
   int depth = 0;
   initial ack = 1'h0;
   initial done = 1'h0;
   // Ack is a one-cycle pulse; a preempted handler restarts its run count
   always @(negedge sys_clk) begin
      ack <= irq_req && !ack;
      done <= !(irq_req && !ack) && cnt == 1;
      if (irq_req && !ack) begin
         depth <= depth + 1;
         cnt <= run_len;
      end else if (cnt == 1) begin
         depth <= depth - 1;
         cnt <= (depth > 1) ? run_len : 0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ---- verif/cpirq_ctrl_sva.sv ----
`timescale 1ns/1ns
// Port-level checks of the request path, PC stack and read port
module cpirq_ctrl_sva
   import cpirq_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire cpirq_reg_req_t reg_req,
   input wire cpirq_seq_t seq,
   input wire logic emu_irq,
   input wire logic [15:0] reg_rdata,
   input wire logic irq_req,
   input wire logic emu_req,
   input wire logic [3:0] irq_slot,
   input wire logic [23:0] irq_vector,
   input wire logic [CPIRQ_SLOTS-1:0] irq_active,
   input wire logic [5:0] pc_stack_level
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_VECTOR: assert property (irq_req |-> irq_vector == {15'h0000, irq_slot, 5'h00})
      else $error("vector does not match slot");
   AST_QUIET_RESET: assert property ($past(sys_rst) |-> !irq_req)
      else $error("request right after reset");
   AST_ACK_TAKES: assert property (irq_req && seq.ack |=> !irq_req && irq_active[$past(irq_slot)])
      else $error("ack did not start the handler");
   AST_REQ_HOLDS: assert property (irq_req && !seq.ack && !seq.dis_int && !reg_req.wr |=> irq_req)
      else $error("request dropped without ack");
   AST_DISABLE: assert property (seq.dis_int |=> ##1 (!irq_req || irq_slot == CPIRQ_SLOT_RESET))
      else $error("request while disabled");
   // Emulator path needs three clean cycles of history
   AST_EMU_DELAY: assert property (!$past(sys_rst, 3) && !$past(sys_rst, 2) && !$past(sys_rst) |->
      emu_req == $past(emu_irq, 3)) else $error("emulator request latency");
   AST_PC_PUSH: assert property (seq.pc_push && !seq.pc_pop && pc_stack_level < 6'h21 |=>
      pc_stack_level == $past(pc_stack_level) + 6'h01) else $error("pc level push");
   AST_RDATA_HOLD: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
      else $error("read data moved without read");
   COV_ACK: cover property (irq_req && seq.ack);
   COV_DONE: cover property (seq.done && irq_active != 16'h0000);
   COV_EMU: cover property ($rose(emu_req));
endmodule

// ---- verif/cpirq_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected %0t got %h want %h", $time, a, b); end end
// Directed bench over the register port and sequencer handshake
module cpirq_ctrl_tb_top;
   import cpirq_pkg::*;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   cpirq_reg_req_t rq = '0;
   cpirq_seq_t seq;
   logic ack, done, irq_req, emu_req;
   logic ena = 1'h0, dis = 1'h0, pcu = 1'h0, pco = 1'h0, lpu = 1'h0, lpo = 1'h0, emu = 1'h0;
   logic [31:0] pirq = '0;
   logic [15:0] csrc = '0, reg_rdata, irq_active;
   logic [3:0] irq_slot, lp_lvl;
   logic [23:0] irq_vector;
   logic [5:0] pc_lvl;
   logic [4:0] st_lvl;
   int n_fail = 0, num_checks = 0, i;
   always #5 sys_clk = ~sys_clk;
   assign seq = '{ack:ack, done:done, ena_int:ena, dis_int:dis, pc_push:pcu, pc_pop:pco,
      loop_push:lpu, loop_pop:lpo};
   cpirq_ctrl uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(rq), .seq(seq), .periph_irq(pirq),
      .emu_irq(emu), .core_irq_src(csrc), .reg_rdata(reg_rdata), .irq_req(irq_req), .emu_req(emu_req),
      .irq_slot(irq_slot), .irq_vector(irq_vector), .irq_active(irq_active), .pc_stack_level(pc_lvl),
      .loop_stack_level(lp_lvl), .stat_stack_level(st_lvl));
   cpirq_seq_model core (.sys_clk(sys_clk), .irq_req(irq_req), .run_len(8'h1E), .ack(ack), .done(done));
   // Register port cycles, launched at the falling edge
   task automatic wr(input logic [3:0] s, input logic [15:0] d);
      rq = '{wr:1'h1, rd:1'h0, sel:s, wdata:d};
      @(negedge sys_clk) rq = '0;
      // Idle edge so the next call never rewrites the request in the same step
      @(negedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] s, input logic [15:0] e);
      rq = '{wr:1'h0, rd:1'h1, sel:s, wdata:16'h0000};
      @(negedge sys_clk) rq = '0;
      @(negedge sys_clk) `CHK(reg_rdata, e)
   endtask
   // Bounded wait for a request, then check winner, vector and entry
   task automatic srv(input logic [3:0] s);
      for (i = 0; i < 60 && irq_req !== 1'h1; i++) @(negedge sys_clk);
      `CHK(irq_slot, s)
      `CHK(irq_vector, CPIRQ_VEC_BASE + 24'(s) * CPIRQ_VEC_STEP)
      repeat (2) @(negedge sys_clk);
      `CHK(irq_active[s], 1'h1)
   endtask
   task automatic quiet(input int n);
      repeat (n) @(negedge sys_clk) `CHK(irq_req, 1'h0)
   endtask
   // Retriggers from level requests drain before the latch is cleared
   task automatic settle();
      pirq = '0;
      repeat (90) @(negedge sys_clk);
      wr(CPIRQ_SEL_LATCH, 16'h0000);
   endtask
   task automatic complete_run();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'h0;
      rd(CPIRQ_SEL_MASK, CPIRQ_MASK_RESET);
      rd(CPIRQ_SEL_CTRL, 16'h0000);
      rd(CPIRQ_SEL_LATCH, 16'h0004);
      for (int r = 0; r < 8; r++) rd(CPIRQ_SEL_MAP0 + 4'(r), CPIRQ_MAP_RESET);
      wr(4'h3, 16'hFFFF);
      rd(4'h3, 16'h0000);
      // Stack levels: three entries is in range, 29 is above it
      wr(CPIRQ_SEL_LATCH, 16'h0000);
      pcu = 1'h1;
      lpu = 1'h1;
      repeat (3) @(negedge sys_clk);
      lpu = 1'h0;
      lpo = 1'h1;
      `CHK(lp_lvl, 4'h3)
      repeat (3) @(negedge sys_clk);
      lpo = 1'h0;
      `CHK(lp_lvl, 4'h0)
      repeat (23) @(negedge sys_clk);
      pcu = 1'h0;
      `CHK(pc_lvl, 6'h1D)
      // Latch bit lands one edge after the level crosses 28
      @(negedge sys_clk);
      rd(CPIRQ_SEL_LATCH, 16'h0004);
      wr(CPIRQ_SEL_LATCH, 16'h0000);
      pco = 1'h1;
      repeat (26) @(negedge sys_clk);
      pco = 1'h0;
      rd(CPIRQ_SEL_LATCH, 16'h0000);
      // Sources 7 and 6 share code 3, source 5 carries a disabling code
      wr(CPIRQ_SEL_MAP0 + 4'h1, 16'h33CF);
      wr(CPIRQ_SEL_MASK, 16'hFFF0);
      wr(CPIRQ_SEL_CTRL, 16'h0002);
      pirq[5] = 1'h1;
      quiet(8);
      pirq[7] = 1'h1;
      srv(4'h7);
      settle();
      pirq[6] = 1'h1;
      srv(4'h7);
      settle();
      wr(CPIRQ_SEL_LATCH, 16'h0210);
      srv(4'h4);
      srv(4'h9);
      repeat (40) @(negedge sys_clk);
      wr(CPIRQ_SEL_MASK, 16'hFFE0);
      wr(CPIRQ_SEL_LATCH, 16'h0030);
      srv(4'h5);
      rd(CPIRQ_SEL_LATCH, 16'h0010);
      wr(CPIRQ_SEL_LATCH, 16'h0000);
      rd(CPIRQ_SEL_LATCH, 16'h0000);
      repeat (40) @(negedge sys_clk);
      // Power-down ignores the mask but not the global disable
      wr(CPIRQ_SEL_MASK, 16'h0000);
      wr(CPIRQ_SEL_LATCH, 16'h0002);
      srv(4'h1);
      repeat (40) @(negedge sys_clk);
      dis = 1'h1;
      @(negedge sys_clk) dis = 1'h0;
      wr(CPIRQ_SEL_LATCH, 16'h0002);
      quiet(6);
      wr(CPIRQ_SEL_LATCH, 16'h0000);
      csrc[0] = 1'h1;
      @(negedge sys_clk) csrc[0] = 1'h0;
      srv(4'h0);
      repeat (40) @(negedge sys_clk);
      // Sequential then nested handling of slot 4 over slot 9
      ena = 1'h1;
      @(negedge sys_clk) ena = 1'h0;
      wr(CPIRQ_SEL_MASK, 16'hFFF0);
      for (int n = 0; n < 2; n++) begin
         wr(CPIRQ_SEL_CTRL, 16'h0002 | 16'(n));
         wr(CPIRQ_SEL_LATCH, 16'h0200);
         srv(4'h9);
         wr(CPIRQ_SEL_LATCH, 16'h0010);
         if (n == 0) quiet(5);
         srv(4'h4);
         if (n == 1) `CHK(irq_active, 16'h0210)
         if (n == 1) `CHK(st_lvl, 5'h02)
         repeat (80) @(negedge sys_clk);
      end
      emu = 1'h1;
      repeat (4) @(negedge sys_clk);
      `CHK(emu_req, 1'h1)
      emu = 1'h0;
      repeat (4) @(negedge sys_clk);
      `CHK(emu_req, 1'h0)
      `CHK(st_lvl, 5'h00)
      complete_run();
   end
endmodule
bind cpirq_ctrl cpirq_ctrl_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .seq(seq),
   .emu_irq(emu_irq), .reg_rdata(reg_rdata), .irq_req(irq_req), .emu_req(emu_req), .irq_slot(irq_slot),
   .irq_vector(irq_vector), .irq_active(irq_active), .pc_stack_level(pc_stack_level));
